//--- rtl/rf_frontend_timer3.sv
// Timer three: 16-bit down counter with byte registers, start modes and stop on receive
`timescale 1ns/10ps
`include "timer3_defines.svh"
// Overview of operation
// [R1] With stop-on-receive set, the timer halts once four frame bits arrive.
// [R2] In either trimming mode, reception never halts the timer.
// [R3] Start mode 00b: the timer starts only on an explicit start.
// [R4] Start mode 01b: the timer starts when a transmission ends.
// [R5] Start mode 10b: trim run between oscillator rising edges, no underflow.
// [R6] Start mode 11b: trim run between oscillator rising edges, underflow allowed.
// [R7] Auto-reload set: at underflow, reload from the reload word and continue.
// [R8] Auto-reload clear: count down to zero, then stop with no reload.
// [R9] Every underflow sets the underflow interrupt request flag.
// [R10] Tick source 00b: count on every system clock.
// [R11] Tick source 01b: count at the system clock divided by 64.
// [R12] Tick source 10b: count once per first sibling counter underflow.
// [R13] Tick source 11b: count once per second sibling counter underflow.
// [R14] Each start loads the counter with the 16-bit reload word.
// [R15] Reload byte writes do not disturb a running countdown.
// [R16] The live count reads back as high and low read-only bytes.
// [R17] Software must not read the count bytes during reception.
// [R18] Control: stop-on-receive b7, start mode b5:4, auto-reload b3, tick b1:0.
// [R19] Running, count drops by one per tick; underflow when leaving zero.
module rf_frontend_timer3 (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Byte register port
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWrData,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // Explicit start and stop commands
  input wire logic startNow,
  input wire logic stopNow,
  // Transceiver events
  input wire logic txEnd,
  input wire logic rxActive,
  input wire logic rxBitStrobe,
  // Slow oscillator pin used for trimming
  input wire logic slowOscIn,
  // Cascade underflows of the sibling counters
  input wire logic sibling0Underflow,
  input wire logic sibling1Underflow,
  // Status and events
  output logic timerRunning,
  output logic underflowPulse,
  output logic underflowIrqSet
);

  // Control fields
  logic stopOnReceive;
  timer3_pkg::start_mode_t startModeSel;
  logic autoReloadEn;
  timer3_pkg::tick_src_t tickSourceSel;

  // Reload word and live count
  logic [7:0] reloadHighByte;
  logic [7:0] reloadLowByte;
  logic [15:0] reloadWord;
  logic [15:0] count;

  // Sequencing
  timer3_pkg::timer_state_t state;
  timer3_pkg::timer_state_t next_state;
  logic [2:0] rxBitCount;
  logic slowEdge;
  logic tick;
  logic trimMode;
  logic startEvent;
  logic rxHalt;
  logic atZero;
  logic underflowEvent;
  logic stopAtUnderflow;
  logic [7:0] next_rdData;

  // Reserved control bits read back as zero
  function automatic logic [7:0] control_image(
    input logic stopRx,
    input timer3_pkg::start_mode_t mode,
    input logic autoRel,
    input timer3_pkg::tick_src_t src
  );
    logic [7:0] img;
    img = `BYTE_ZERO;
    img[`STOP_RX_BIT] = stopRx;
    img[`START_MSB:`START_LSB] = mode;
    img[`AUTO_RELOAD_BIT] = autoRel;
    img[`TICK_SRC_MSB:`TICK_SRC_LSB] = src;
    return img & `CTRL_WRITE_MASK;
  endfunction : control_image

  function automatic logic is_write(
    input logic wr,
    input logic [7:0] addr,
    input logic [7:0] target
  );
    return wr && (addr == target);
  endfunction : is_write

  edge_sync slow_osc_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pinIn(slowOscIn),
    .risePulse(slowEdge)
  );

  tick_source tick_gen (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tickSel(tickSourceSel),
    .sibling0Underflow(sibling0Underflow),
    .sibling1Underflow(sibling1Underflow),
    .tick(tick)
  );

  // Control register writes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stopOnReceive <= 1'b0;
      startModeSel <= timer3_pkg::START_MANUAL;
      autoReloadEn <= 1'b0;
      tickSourceSel <= timer3_pkg::TICK_SYSTEM;
    end else if (is_write(regWrite, regAddr, `CTRL_ADDR)) begin
      stopOnReceive <= regWrData[`STOP_RX_BIT]; // [R18]
      startModeSel <= timer3_pkg::start_mode_t'(regWrData[`START_MSB:`START_LSB]); // [R18]
      autoReloadEn <= regWrData[`AUTO_RELOAD_BIT]; // [R18]
      tickSourceSel <= timer3_pkg::tick_src_t'(regWrData[`TICK_SRC_MSB:`TICK_SRC_LSB]); // [R18]
    end
  end

  // Reload bytes only feed the counter at a start or an auto-reload underflow, so writes never touch a running count
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reloadHighByte <= `BYTE_ZERO;
    end else if (is_write(regWrite, regAddr, `RELOAD_HI_ADDR)) begin
      reloadHighByte <= regWrData; // [R15]
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reloadLowByte <= `BYTE_ZERO;
    end else if (is_write(regWrite, regAddr, `RELOAD_LO_ADDR)) begin
      reloadLowByte <= regWrData; // [R15]
    end
  end

  assign reloadWord = {reloadHighByte, reloadLowByte}; // [R14]

  assign trimMode = (startModeSel == timer3_pkg::START_TRIM_HOLD) ||
                    (startModeSel == timer3_pkg::START_TRIM_WRAP);

  // Received-bit count within the current frame; cleared between frames
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rxBitCount <= `RX_COUNT_ZERO;
    end else if (!rxActive) begin
      rxBitCount <= `RX_COUNT_ZERO;
    end else if (rxBitStrobe && (rxBitCount != `RX_STOP_BITS)) begin
      rxBitCount <= rxBitCount + `RX_COUNT_ONE;
    end
  end

  // Halt once, on the strobe that completes the fourth bit
  assign rxHalt = stopOnReceive && !trimMode && // [R1] [R2]
                  rxActive && rxBitStrobe &&
                  (rxBitCount == (`RX_STOP_BITS - `RX_COUNT_ONE));

  // Start sources by mode; trimming starts on an oscillator edge after arming
  always_comb begin
    unique case (startModeSel)
      timer3_pkg::START_MANUAL: startEvent = startNow; // [R3]
      timer3_pkg::START_AFTER_TX: startEvent = startNow || txEnd; // [R4]
      timer3_pkg::START_TRIM_HOLD: startEvent = (state == timer3_pkg::TRIM_ARMED) && slowEdge; // [R5]
      timer3_pkg::START_TRIM_WRAP: startEvent = (state == timer3_pkg::TRIM_ARMED) && slowEdge; // [R6]
    endcase
  end

  assign atZero = (count == `COUNT_ZERO);

  // Trim without underflow holds at zero instead of passing through it
  assign underflowEvent = (state == timer3_pkg::COUNTING) && tick && atZero &&
                          (startModeSel != timer3_pkg::START_TRIM_HOLD); // [R5] [R19]

  assign stopAtUnderflow = underflowEvent && !autoReloadEn; // [R8]

  // Sequencing of the run state
  always_comb begin
    next_state = state;
    unique case (state)
      timer3_pkg::IDLE: begin
        if (trimMode && startNow) begin
          next_state = timer3_pkg::TRIM_ARMED;
        end else if (!trimMode && startEvent) begin
          next_state = timer3_pkg::COUNTING;
        end
      end
      timer3_pkg::TRIM_ARMED: begin
        if (stopNow || !trimMode) begin
          next_state = timer3_pkg::IDLE;
        end else if (startEvent) begin
          next_state = timer3_pkg::COUNTING; // [R5] [R6]
        end
      end
      timer3_pkg::COUNTING: begin
        // A restart in the underflow cycle wins, as the counter reloads then too
        if (stopNow || rxHalt) begin
          next_state = timer3_pkg::IDLE; // [R1]
        end else if (!trimMode && startEvent) begin
          next_state = timer3_pkg::COUNTING; // [R14]
        end else if (stopAtUnderflow) begin
          next_state = timer3_pkg::IDLE; // [R8]
        end else if (trimMode && slowEdge) begin
          next_state = timer3_pkg::IDLE; // [R5] [R6]
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= timer3_pkg::IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Counter: a start reloads, ticks decrement, underflow reloads when auto-reload is set
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count <= `COUNT_RESET;
    end else if (startEvent && (state != timer3_pkg::IDLE || !trimMode) &&
                 !(state == timer3_pkg::COUNTING && trimMode)) begin
      count <= reloadWord; // [R14]
    end else if (state == timer3_pkg::COUNTING && tick && !rxHalt && !stopNow) begin
      if (underflowEvent && autoReloadEn) begin
        count <= reloadWord; // [R7]
      end else if (!atZero) begin
        count <= count - `COUNT_ONE; // [R19]
      end
    end
  end

  // Cascade output and interrupt request set, one cycle per underflow
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      underflowPulse <= 1'b0;
      underflowIrqSet <= 1'b0;
    end else begin
      underflowPulse <= underflowEvent && !rxHalt && !stopNow;
      underflowIrqSet <= underflowEvent && !rxHalt && !stopNow; // [R9]
    end
  end

  assign timerRunning = (state == timer3_pkg::COUNTING);

  // Register read data; count bytes are sampled live, so a read mid-count is not atomic
  always_comb begin
    next_rdData = `BYTE_ZERO;
    unique case (regAddr)
      `CTRL_ADDR: next_rdData = control_image(stopOnReceive, startModeSel,
                                              autoReloadEn, tickSourceSel);
      `RELOAD_HI_ADDR: next_rdData = reloadHighByte;
      `RELOAD_LO_ADDR: next_rdData = reloadLowByte;
      `COUNT_HI_ADDR: next_rdData = count[15:8]; // [R16]
      `COUNT_LO_ADDR: next_rdData = count[7:0]; // [R16]
      default: next_rdData = `BYTE_ZERO;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= `BYTE_ZERO;
    end else if (regRead) begin
      regRdData <= next_rdData;
    end
  end

endmodule : rf_frontend_timer3

//--- rtl/timer3_defines.svh
// Register addresses, field positions, reset values and timing counts of timer three
`ifndef TIMER3_DEFINES_SVH
`define TIMER3_DEFINES_SVH

// Byte register addresses
`define CTRL_ADDR 8'h1E
`define RELOAD_HI_ADDR 8'h1F
`define RELOAD_LO_ADDR 8'h20
`define COUNT_HI_ADDR 8'h21
`define COUNT_LO_ADDR 8'h22

// Control register fields
`define STOP_RX_BIT 7
`define START_MSB 5
`define START_LSB 4
`define AUTO_RELOAD_BIT 3
`define TICK_SRC_MSB 1
`define TICK_SRC_LSB 0
`define CTRL_WRITE_MASK 8'hBB

// Reset values
`define CTRL_RESET 8'h00
`define RELOAD_RESET 16'h0000
`define COUNT_RESET 16'h0000
`define BYTE_ZERO 8'h00
`define COUNT_ZERO 16'h0000
`define COUNT_ONE 16'h0001

// Slow tick rate derived from the system clock rate
`define SYS_CLK_HZ 13560000
`define SLOW_TICK_HZ 211875
`define PRESCALE_DIV (`SYS_CLK_HZ / `SLOW_TICK_HZ)
`define PRESCALE_LAST 6'h3F
`define PRESCALE_ZERO 6'h00

// Received bits after which a frame may halt the timer
`define RX_STOP_BITS 3'h4
`define RX_COUNT_ZERO 3'h0
`define RX_COUNT_ONE 3'h1

`endif

//--- rtl/timer3_pkg.sv
// Types shared by the timer three design files
package timer3_pkg;

  typedef enum logic [1:0] {
    START_MANUAL = 2'h0,
    START_AFTER_TX = 2'h1,
    START_TRIM_HOLD = 2'h2,
    START_TRIM_WRAP = 2'h3
  } start_mode_t;

  typedef enum logic [1:0] {
    TICK_SYSTEM = 2'h0,
    TICK_SLOW = 2'h1,
    TICK_SIBLING0 = 2'h2,
    TICK_SIBLING1 = 2'h3
  } tick_src_t;

  typedef enum {
    IDLE,
    TRIM_ARMED,
    COUNTING
  } timer_state_t;

endpackage : timer3_pkg

//--- rtl/edge_sync.sv
// Two-flop synchroniser with rising-edge pulse for an asynchronous pin
`timescale 1ns/10ps
module edge_sync (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Pin and edge pulse
  input wire logic pinIn,
  output logic risePulse
);

  logic meta;
  logic stable;
  logic stableLast;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b0;
      stable <= 1'b0;
    end else begin
      meta <= pinIn;
      stable <= meta;
    end
  end

  // Edge taken from the second stage only, never the metastable one
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stableLast <= 1'b0;
    end else begin
      stableLast <= stable;
    end
  end

  assign risePulse = stable & ~stableLast;

endmodule : edge_sync

//--- rtl/tick_source.sv
// Tick selection: system clock, divide-by-64 slow tick, or a sibling counter underflow
`timescale 1ns/10ps
`include "timer3_defines.svh"
module tick_source (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Selection and cascade inputs
  input wire timer3_pkg::tick_src_t tickSel,
  input wire logic sibling0Underflow,
  input wire logic sibling1Underflow,
  // Selected tick
  output logic tick
);

  logic [5:0] prescale;
  logic slowTick;

  // Free-running so that the slow tick rate does not depend on when the timer starts
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prescale <= `PRESCALE_ZERO;
    end else begin
      prescale <= prescale + 6'h01;
    end
  end

  assign slowTick = (prescale == `PRESCALE_LAST);

  always_comb begin
    unique case (tickSel)
      timer3_pkg::TICK_SYSTEM: tick = 1'b1; // [R10]
      timer3_pkg::TICK_SLOW: tick = slowTick; // [R11]
      timer3_pkg::TICK_SIBLING0: tick = sibling0Underflow; // [R12]
      timer3_pkg::TICK_SIBLING1: tick = sibling1Underflow; // [R13]
    endcase
  end

endmodule : tick_source

//--- verif/rf_frontend_timer3_asserts.sv
// Port-level checker of timer three
`timescale 1ns/10ps
`include "timer3_defines.svh"
module rf_frontend_timer3_asserts (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWrData,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  // Commands and events
  input wire logic startNow,
  input wire logic stopNow,
  input wire logic txEnd,
  input wire logic rxActive,
  input wire logic rxBitStrobe,
  input wire logic slowOscIn,
  input wire logic sibling0Underflow,
  input wire logic sibling1Underflow,
  // Status
  input wire logic timerRunning,
  input wire logic underflowPulse,
  input wire logic underflowIrqSet
);
  logic [7:0] ctrl;
  // Shadow of the control byte so that mode-dependent rules can be judged
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `CTRL_RESET;
    end else if (regWrite && regAddr == `CTRL_ADDR) begin
      ctrl <= regWrData & `CTRL_WRITE_MASK;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  chk_irq_pair: assert property (underflowIrqSet == underflowPulse)
    else $error("irq set differs from underflow pulse");
  chk_manual_start: assert property (
    startNow && !stopNow && !rxBitStrobe && !ctrl[5] |=> timerRunning)
    else $error("explicit start did not run the timer");
  chk_tx_start: assert property (
    txEnd && ctrl[5:4] == 2'h1 && !stopNow && !rxBitStrobe |=> timerRunning)
    else $error("end of transmission did not start the timer");
  chk_tx_ignored: assert property (
    txEnd && ctrl[5:4] == 2'h0 && !startNow && !timerRunning |=> !timerRunning)
    else $error("timer started by itself");
  chk_oneshot_stop: assert property (
    underflowPulse && !ctrl[3] && !ctrl[5] && !$past(startNow) && !$past(txEnd)
    |-> !timerRunning)
    else $error("timer kept running after underflow");
  chk_reload_go: assert property (
    underflowPulse && ctrl[3] && !ctrl[5] && !$past(stopNow) && !$past(rxBitStrobe)
    |-> timerRunning)
    else $error("timer stopped despite auto reload");
  chk_hold_quiet: assert property (
    ctrl[5:4] == 2'h2 && $past(ctrl[5:4]) == 2'h2 |-> !underflowPulse)
    else $error("underflow in trim mode without underflow");
  chk_idle_quiet: assert property (underflowPulse |-> $past(timerRunning))
    else $error("underflow while not counting");
  chk_ctrl_read: assert property (
    regRead && !regWrite && regAddr == `CTRL_ADDR |=> regRdData == $past(ctrl))
    else $error("control read back wrong");
  chk_void_read: assert property (
    regRead && regAddr > `COUNT_LO_ADDR |=> regRdData == `BYTE_ZERO)
    else $error("unmapped read not zero");
endmodule : rf_frontend_timer3_asserts
bind rf_frontend_timer3 rf_frontend_timer3_asserts i_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .regAddr(regAddr), .regWrite(regWrite), .regWrData(regWrData), .regRead(regRead),
  .regRdData(regRdData), .startNow(startNow), .stopNow(stopNow), .txEnd(txEnd),
  .rxActive(rxActive), .rxBitStrobe(rxBitStrobe), .slowOscIn(slowOscIn),
  .sibling0Underflow(sibling0Underflow), .sibling1Underflow(sibling1Underflow),
  .timerRunning(timerRunning), .underflowPulse(underflowPulse),
  .underflowIrqSet(underflowIrqSet));

//--- verif/tb_rf_frontend_timer3.sv
// Self-checking bench for timer three
`timescale 1ns/10ps
`include "timer3_defines.svh"
module tb_rf_frontend_timer3;
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic [7:0] regRdData;
  logic regWrite = 1'h0;
  logic regRead = 1'h0;
  logic startNow = 1'h0;
  logic stopNow = 1'h0;
  logic txEnd = 1'h0;
  logic rxActive = 1'h0;
  logic rxBitStrobe = 1'h0;
  logic slowOscIn = 1'h0;
  logic sib0 = 1'h0;
  logic sib1 = 1'h0;
  logic timerRunning;
  logic underflowPulse;
  logic underflowIrqSet;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  int n;
  logic [31:0] seed = 32'h000060D0;
  logic [15:0] rl;
  always #20 clk_sys = ~clk_sys;
  rf_frontend_timer3 i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
    .regWrite(regWrite), .regWrData(regWrData), .regRead(regRead),
    .regRdData(regRdData), .startNow(startNow), .stopNow(stopNow), .txEnd(txEnd),
    .rxActive(rxActive), .rxBitStrobe(rxBitStrobe), .slowOscIn(slowOscIn),
    .sibling0Underflow(sib0), .sibling1Underflow(sib1), .timerRunning(timerRunning),
    .underflowPulse(underflowPulse), .underflowIrqSet(underflowIrqSet));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  // Cycles from the end of a start strobe to the visible underflow, system tick:
  // load on the start edge, r ticks to zero, the pulse on the edge of the next tick
  function automatic logic [15:0] firstGap(input logic [15:0] r);
    return r;
  endfunction : firstGap
  function automatic logic [15:0] left(input logic [15:0] r, input int k);
    return r - 16'(k);
  endfunction : left
  task automatic final_report;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : cyc
  // Strobes get an idle cycle after them so no signal is set twice in one step
  task automatic pls(ref logic s);
    s = 1'h1;
    cyc(1);
    s = 1'h0;
    cyc(1);
  endtask : pls
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    pls(regWrite);
  endtask : wr
  task automatic wrRl(input logic [15:0] r);
    wr(`RELOAD_HI_ADDR, r[15:8]);
    wr(`RELOAD_LO_ADDR, r[7:0]);
  endtask : wrRl
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    regAddr = a;
    regRead = 1'h1;
    cyc(1);
    regRead = 1'h0;
    d = regRdData;
    cyc(1);
  endtask : rd
  task automatic rc(output logic [15:0] c);
    rd(`COUNT_HI_ADDR, c[15:8]);
    rd(`COUNT_LO_ADDR, c[7:0]);
  endtask : rc
  task automatic wp;
    n = 0;
    while (underflowPulse !== 1'h1 && n < 3000) begin
      cyc(1);
      n++;
    end
  endtask : wp
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    logic [7:0] d;
    logic [15:0] c;
    repeat (16) @(posedge clk_sys);
    #1;
    rst_n = 1'h1;
    cyc(1);
    for (int a = 8'h1E; a <= 8'h23; a++) begin
      wr(8'h21, 8'hFF);
      rd(8'(a), d);
      chk(16'(d), 16'h0000);
    end
    wr(`CTRL_ADDR, 8'hFF);
    rd(`CTRL_ADDR, d);
    chk(16'(d), 16'h00BB);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      rl = 16'h0002 + 16'(seed[4:0]);
      wrRl(rl);
      wr(`CTRL_ADDR, {4'h0, i[0], 3'h0});
      pls(startNow);
      wp();
      chk(16'(n), firstGap(rl));
      chk(16'(underflowIrqSet), 16'h0001);
      cyc(1);
      chk(16'(timerRunning), 16'(i[0]));
      if (i[0]) begin
        wp();
        chk(16'(n), rl);
        pls(stopNow);
      end
    end
    seed = xs(seed);
    rl = 16'h0002 + 16'(seed[2:0]);
    wrRl(rl);
    wr(`CTRL_ADDR, 8'h01);
    pls(startNow);
    wp();
    chk(16'(n >= 64 * rl - 2 && n <= 64 * (rl + 1) + 2), 16'h0001);
    for (int s = 2; s < 4; s++) begin
      seed = xs(seed);
      rl = seed[15:0] | 16'h0100;
      wrRl(rl);
      wr(`CTRL_ADDR, 8'(s));
      pls(startNow);
      wrRl(~rl);
      for (int k = 0; k < 5; k++) begin
        if (s == 2) pls(sib0);
        else pls(sib1);
        if (s == 2) pls(sib1);
        else pls(sib0);
      end
      rc(c); // read outside reception
      chk(c, left(rl, 5));
      pls(startNow);
      rc(c);
      chk(c, ~rl);
    end
    pls(stopNow);
    wr(`CTRL_ADDR, 8'h12);
    pls(txEnd);
    chk(16'(timerRunning), 16'h0001);
    rc(c);
    chk(c, ~rl);
    pls(stopNow);
    wr(`CTRL_ADDR, 8'h02);
    pls(txEnd);
    chk(16'(timerRunning), 16'h0000);
    for (int b = 0; b < 2; b++) begin
      wr(`CTRL_ADDR, {b[0], 7'h02});
      pls(startNow);
      rxActive = 1'h1;
      repeat (3) pls(rxBitStrobe);
      chk(16'(timerRunning), 16'h0001);
      pls(rxBitStrobe);
      chk(16'(timerRunning), 16'(!b[0]));
      rxActive = 1'h0;
      pls(stopNow);
    end
    wrRl(16'h0005);
    wr(`CTRL_ADDR, 8'hA0);
    pls(startNow);
    slowOscIn = 1'h1;
    cyc(6);
    chk(16'(timerRunning), 16'h0001);
    rxActive = 1'h1;
    repeat (4) pls(rxBitStrobe);
    rxActive = 1'h0;
    chk(16'(timerRunning), 16'h0001);
    slowOscIn = 1'h0;
    cyc(4);
    slowOscIn = 1'h1;
    cyc(6);
    chk(16'(timerRunning), 16'h0000);
    wr(`CTRL_ADDR, 8'h30);
    slowOscIn = 1'h0;
    pls(startNow);
    slowOscIn = 1'h1;
    wp();
    chk(16'(n < 20), 16'h0001);
    pls(stopNow);
    final_report();
  end
endmodule : tb_rf_frontend_timer3
